/* hdl/nt_cfg_pkg.sv */
// package: offsets, field positions and reset values of the virtual-side config header front
package nt_cfg_pkg;

  // =====================================================================
  // register offsets (byte addresses within config space)
  localparam logic [11:0] OFF_IDENT  = 12'h000;
  localparam logic [11:0] OFF_CMDSTS = 12'h004;

  // =====================================================================
  // command field positions
  localparam int CMD_IO_EN     = 0;
  localparam int CMD_MEM_EN    = 1;
  localparam int CMD_MASTER_EN = 2;
  localparam int CMD_PERR_EN   = 6;
  localparam int CMD_SERR_EN   = 8;
  localparam int CMD_INT_DIS   = 10;

  // writable command bits: 0,1,2,6,8,10
  localparam logic [15:0] CMD_RW_MASK = 16'h0547;

  // =====================================================================
  // status field positions (bit numbers within the 32-bit word)
  localparam int STS_INT       = 19;
  localparam int STS_CAP_LIST  = 20;
  localparam int STS_MDPERR    = 24;
  localparam int STS_SIG_TABT  = 27;
  localparam int STS_SIG_SERR  = 30;
  localparam int STS_DET_PERR  = 31;

  // =====================================================================
  // reset values
  localparam logic [15:0] CMD_RESET   = 16'h0000;
  localparam logic [3:0]  FLAGS_RESET = 4'h0;
  localparam logic        CAP_RESET   = 1'b1;

  // flag vector index order: {det_perr, sig_serr, sig_tabt, mdperr}
  localparam int FL_MDPERR   = 0;
  localparam int FL_SIG_TABT = 1;
  localparam int FL_SIG_SERR = 2;
  localparam int FL_DET_PERR = 3;
  localparam int FLAG_COUNT  = 4;

endpackage : nt_cfg_pkg

/* hdl/nt_flag_bank.sv */
// sticky write-one-to-clear event flags, set wins over clear
`timescale 1ns/1ns
module nt_flag_bank #(
  parameter int N = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         init_load,
  input  wire logic [N-1:0] init_value,
  input  wire logic [N-1:0] set_ev,
  input  wire logic [N-1:0] clr_ev,
  output logic      [N-1:0] flags_q
);

  logic [N-1:0] flags_d;

  // =====================================================================
  // per-flag next state
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      // set beats a simultaneous clear so no event is lost
      assign flags_d[i] = set_ev[i] | (flags_q[i] & ~clr_ev[i]);
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_q <= '0;
    end else if (init_load) begin
      flags_q <= init_value | set_ev;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule : nt_flag_bank

/* hdl/nt_virtual_cfg_header.sv */
// identification and command/status registers of the virtual-side config header
`timescale 1ns/1ns

// Behaviour
// - read-only manufacturer id, low half, loadable
// - read-only part id, upper half, loadable
// - i/o enable stored, no effect
// - memory enable gates virtual memory requests
// - master enable: forward, or unsupported-request if non-posted
// - unsupported command bits read zero always
// - interrupt disable blocks intx messages
// - system error enable gates error reporting
// - interrupt status shows pending or pin
// - capability list bit resets to one, init load replaces it
// - reserved status bits read zero always
// - parity enable: poisoned write/completion sets bit24
// - bit24 never set by events when parity disabled; init load can still set it
// - poisoned status mirrored into bit24
// - completer-abort completion sets target abort
// - register request over one dword aborts
// - request to missing port aborts
// - write to enabled rom window aborts
// - forwarded abort leaves uncorrectable ca bit
// - sent fatal/nonfatal message sets bit30 if enabled
// - any received poisoned packet sets bit31
module nt_virtual_cfg_header
  import nt_cfg_pkg::*;
#(
  parameter logic [15:0] MFR_ID_DEFAULT  = 16'h1234, // arbitrary neutral value
  parameter logic [15:0] PART_ID_DEFAULT = 16'h5678  // arbitrary neutral value
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // configuration access port
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  // serial eeprom / i2c initialization load
  input  wire logic        init_load,
  input  wire logic [31:0] init_ident,
  input  wire logic [31:0] init_cmdsts,
  // virtual interface memory requests
  input  wire logic        vmem_req,
  output logic             vmem_accept,
  input  wire logic        vmem_to_reg,
  input  wire logic        vmem_multi_dw,
  input  wire logic        vmem_bad_port,
  input  wire logic        vmem_is_write,
  input  wire logic        vmem_rom_hit,
  input  wire logic        rom_enabled,
  // link interface memory requests headed upstream
  input  wire logic        lmem_req,
  input  wire logic        lmem_non_posted,
  output logic             lmem_forward,
  output logic             lmem_ur_cpl,
  // intx
  input  wire logic        intx_pending,
  input  wire logic        legacy_interrupt_pin_n,
  input  wire logic        legacy_pin_enable,
  output logic             intx_msg_allow,
  // error events
  input  wire logic        err_detected,
  output logic             err_report_allow,
  input  wire logic        err_msg_sent,
  input  wire logic        poisoned_wr_fwd,
  input  wire logic        poisoned_cpl_rx,
  input  wire logic        poisoned_any_rx,
  input  wire logic        ue_poisoned_set,
  input  wire logic        ca_cpl_rx,
  output logic             ue_ca_set
);

  // =====================================================================
  // state
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic [15:0] mfr_id_q;
  logic [15:0] part_id_q;
  logic        cap_q;
  logic [31:0] rdata_q;
  logic        rvalid_q;
  logic [FLAG_COUNT-1:0] flags_q;

  // =====================================================================
  // address decode
  wire hit_ident  = cfg_addr == OFF_IDENT;
  wire hit_cmdsts = cfg_addr == OFF_CMDSTS;
  wire wr_cmdsts  = cfg_wr & hit_cmdsts;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  wire [31:0] wmask = be_mask(cfg_be);
  wire [31:0] wbits = cfg_wdata & wmask;

  // only writable bits are stored; unsupported ones stay zero
  assign cmd_d = (cmd_q & ~(wmask[15:0] & CMD_RW_MASK)) | (wbits[15:0] & CMD_RW_MASK);

  // =====================================================================
  // command effects
  wire mem_en    = cmd_q[CMD_MEM_EN];
  wire master_en = cmd_q[CMD_MASTER_EN];
  wire perr_en   = cmd_q[CMD_PERR_EN];
  wire serr_en   = cmd_q[CMD_SERR_EN];
  wire int_dis   = cmd_q[CMD_INT_DIS];

  assign vmem_accept      = vmem_req & mem_en;
  assign lmem_forward     = lmem_req & master_en;
  assign lmem_ur_cpl      = lmem_req & ~master_en & lmem_non_posted;
  assign intx_msg_allow   = ~int_dis;
  assign err_report_allow = serr_en & err_detected;

  // =====================================================================
  // event sources; abort checks only apply to accepted requests
  wire tabt_reg = vmem_accept & vmem_to_reg & vmem_multi_dw;
  wire tabt_prt = vmem_accept & vmem_to_reg & vmem_bad_port;
  wire tabt_rom = vmem_accept & vmem_is_write & vmem_rom_hit & rom_enabled;
  wire tabt_cpl = ca_cpl_rx;

  // forwarded completer abort never touches the uncorrectable ca bit
  assign ue_ca_set = tabt_reg | tabt_prt | tabt_rom;

  wire ev_mdperr = perr_en & (poisoned_wr_fwd | poisoned_cpl_rx | ue_poisoned_set);
  wire ev_tabt   = tabt_cpl | tabt_reg | tabt_prt | tabt_rom;
  wire ev_serr   = serr_en & err_msg_sent;
  wire ev_dperr  = poisoned_any_rx;

  wire [FLAG_COUNT-1:0] set_ev = {ev_dperr, ev_serr, ev_tabt, ev_mdperr};
  wire [FLAG_COUNT-1:0] clr_ev = wr_cmdsts ? {wbits[STS_DET_PERR], wbits[STS_SIG_SERR],
                                              wbits[STS_SIG_TABT], wbits[STS_MDPERR]} : '0;
  wire [FLAG_COUNT-1:0] init_fl = {init_cmdsts[STS_DET_PERR], init_cmdsts[STS_SIG_SERR],
                                   init_cmdsts[STS_SIG_TABT], init_cmdsts[STS_MDPERR]};

  nt_flag_bank #(
    .N          (FLAG_COUNT)
  ) u_flags (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .init_load  (init_load),
    .init_value (init_fl),
    .set_ev     (set_ev),
    .clr_ev     (clr_ev),
    .flags_q    (flags_q)
  );

  // =====================================================================
  // status word assembly; every unlisted bit reads zero
  wire int_status = intx_pending | (legacy_pin_enable & ~legacy_interrupt_pin_n);

  wire [15:0] status_word;
  assign status_word = {flags_q[FL_DET_PERR], flags_q[FL_SIG_SERR], 2'b00,
                        flags_q[FL_SIG_TABT], 2'b00, flags_q[FL_MDPERR],
                        3'b000, cap_q, int_status, 3'b000};

  wire [31:0] ident_word  = {part_id_q, mfr_id_q};
  wire [31:0] cmdsts_word = {status_word, cmd_q};
  wire [31:0] rd_mux      = hit_ident ? ident_word : (hit_cmdsts ? cmdsts_word : 32'h0000_0000);

  // =====================================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_q <= CMD_RESET;
    end else if (init_load) begin
      cmd_q <= init_cmdsts[15:0] & CMD_RW_MASK;
    end else if (wr_cmdsts) begin
      cmd_q <= cmd_d;
    end
  end

  // identity is read-only to software, only init load replaces it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mfr_id_q  <= MFR_ID_DEFAULT;
      part_id_q <= PART_ID_DEFAULT;
      cap_q     <= CAP_RESET;
    end else if (init_load) begin
      mfr_id_q  <= init_ident[15:0];
      part_id_q <= init_ident[31:16];
      cap_q     <= init_cmdsts[STS_CAP_LIST];
    end
  end

  // read data registered: one cycle after cfg_rd
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= cfg_rd;
      if (cfg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign cfg_rdata  = rdata_q;
  assign cfg_rvalid = rvalid_q;

endmodule : nt_virtual_cfg_header

/* testbench/nt_cfg_header_props.sv */
// concurrent checks on the config header ports
`timescale 1ns/1ns
module nt_cfg_header_props
  import nt_cfg_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_rvalid,
  input wire logic        init_load,
  input wire logic        vmem_req,
  input wire logic        vmem_accept,
  input wire logic        lmem_req,
  input wire logic        lmem_non_posted,
  input wire logic        lmem_forward,
  input wire logic        lmem_ur_cpl,
  input wire logic        err_detected,
  input wire logic        err_report_allow,
  input wire logic        intx_msg_allow,
  input wire logic        ca_cpl_rx,
  input wire logic        ue_ca_set
);
  // =====================================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_rd; cfg_rd && cfg_addr == OFF_CMDSTS; endsequence
  property p_rvalid; cfg_rvalid == $past(cfg_rd); endproperty
  property p_cmd_rsv; s_rd |=> (cfg_rdata & 32'h0000_fab8) == 32'h0; endproperty
  property p_sts_rsv; s_rd |=> (cfg_rdata & 32'h06e7_0000) == 32'h0; endproperty
  property p_acc; vmem_accept |-> vmem_req; endproperty
  property p_lmem; lmem_req && lmem_non_posted |-> lmem_forward ^ lmem_ur_cpl; endproperty
  property p_err; err_report_allow |-> err_detected; endproperty
  // the disable bit only moves after a config write or a load
  property p_intx; !$stable(intx_msg_allow) |-> $past(cfg_wr || init_load); endproperty
  property p_ca; ca_cpl_rx && !vmem_req |-> !ue_ca_set; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer mistimed");
  a_cmd_rsv: assert property (p_cmd_rsv) else $error("command spare bit set");
  a_sts_rsv: assert property (p_sts_rsv) else $error("status spare bit set");
  a_acc: assert property (p_acc) else $error("accept without request");
  a_lmem: assert property (p_lmem) else $error("link request mishandled");
  a_err: assert property (p_err) else $error("report without error");
  a_intx: assert property (p_intx) else $error("intx gate moved alone");
  a_ca: assert property (p_ca) else $error("forwarded abort logged");
endmodule : nt_cfg_header_props

bind nt_virtual_cfg_header nt_cfg_header_props i_props (.clk_sys, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_rdata,
  .cfg_rvalid, .init_load, .vmem_req, .vmem_accept, .lmem_req, .lmem_non_posted, .lmem_forward, .lmem_ur_cpl,
  .err_detected, .err_report_allow, .intx_msg_allow, .ca_cpl_rx, .ue_ca_set);

/* testbench/rc_model.sv */
// root complex model issuing config writes and reads
`timescale 1ns/1ns
module rc_model (
  input  wire logic        clk_sys,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rvalid,
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic      [11:0] cfg_addr,
  output logic      [3:0]  cfg_be,
  output logic      [31:0] cfg_wdata
);
  // =====================================================================
  // requests; released lines carry the inverse so stale values never pass
  initial begin
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_addr  = 12'hfff;
    cfg_be    = 4'hf;
    cfg_wdata = 32'h0;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    #1;
    cfg_addr  = a;
    cfg_wdata = d;
    cfg_wr    = 1'b1;
    @(posedge clk_sys);
    #1;
    cfg_wr    = 1'b0;
    cfg_addr  = ~a;
    cfg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    #1;
    cfg_addr = a;
    cfg_rd   = 1'b1;
    @(posedge clk_sys);
    #1;
    cfg_rd   = 1'b0;
    cfg_addr = ~a;
    d        = cfg_rvalid ? cfg_rdata : ~cfg_rdata;
  endtask : rd
endmodule : rc_model

/* testbench/nt_virtual_cfg_header_bench.sv */
// self-checking bench for the virtual-side config header front
`timescale 1ns/1ns
module nt_virtual_cfg_header_bench;
  import nt_cfg_pkg::*;
  logic        clk_sys, rst, cfg_wr, cfg_rd, cfg_rvalid, vmem_accept, lmem_forward, lmem_ur_cpl;
  logic        intx_msg_allow, err_report_allow, ue_ca_set;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, init_ident, init_cmdsts, lf, rdv;
  logic [19:0] s;
  int          n_mismatch, samples_checked;
  // =====================================================================
  // design and root complex model
  nt_virtual_cfg_header i_nt_virtual_cfg_header (.clk_sys, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata, .cfg_rvalid, .init_load(s[19]), .init_ident, .init_cmdsts, .vmem_req(s[0]), .vmem_accept,
    .vmem_to_reg(s[1]), .vmem_multi_dw(s[2]), .vmem_bad_port(s[3]), .vmem_is_write(s[4]), .vmem_rom_hit(s[5]),
    .rom_enabled(s[6]), .lmem_req(s[7]), .lmem_non_posted(s[8]), .lmem_forward, .lmem_ur_cpl,
    .intx_pending(s[9]), .legacy_interrupt_pin_n(s[10]), .legacy_pin_enable(s[11]), .intx_msg_allow,
    .err_detected(s[12]), .err_report_allow, .err_msg_sent(s[13]), .poisoned_wr_fwd(s[14]),
    .poisoned_cpl_rx(s[15]), .poisoned_any_rx(s[16]), .ue_poisoned_set(s[17]), .ca_cpl_rx(s[18]), .ue_ca_set);
  rc_model i_rc_model (.clk_sys, .cfg_rdata, .cfg_rvalid, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata);
  // =====================================================================
  // helpers
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt
  function automatic logic [4:0] expo(input logic [15:0] c, input logic [19:0] v);
    return {v[0] & c[1], v[7] & c[2], v[7] & ~c[2] & v[8], v[12] & c[8], ~c[10]};
  endfunction : expo
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic pulse(input logic [19:0] v);
    @(posedge clk_sys);
    #1;
    s = v;
    @(posedge clk_sys);
    #1;
    s = 20'h0;
  endtask : pulse
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    wrap_up();
  end
  // =====================================================================
  // tests
  initial begin
    rst = 1'b1;
    s = 20'h0;
    lf = 32'h3321a4ca;
    init_ident = 32'h0;
    init_cmdsts = 32'h0010_0000;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    i_rc_model.rd(OFF_IDENT, rdv);
    chk(rdv, 32'h5678_1234);
    i_rc_model.rd(OFF_CMDSTS, rdv);
    chk(rdv, 32'h0010_0000);
    $display("test reset done");
    // random command words with the request qualifiers wiggling; only target-abort events fire
    for (int i = 0; i < 24; i++) begin
      lf = nxt(lf);
      i_rc_model.wr(OFF_CMDSTS, {16'h0, lf[15:0]});
      s = lf[31:12] & 20'h01fff;
      i_rc_model.rd(OFF_CMDSTS, rdv);
      chk(rdv & 32'hf7ff_ffff, {12'h001, s[9] | (s[11] & ~s[10]), 3'h0, lf[15:0] & CMD_RW_MASK});
      chk({27'h0, vmem_accept, lmem_forward, lmem_ur_cpl, err_report_allow, intx_msg_allow}, {27'h0, expo(lf[15:0], s)});
      chk({31'h0, ue_ca_set}, {31'h0, s[0] & lf[1] & ((s[1] & (s[2] | s[3])) | (s[4] & s[5] & s[6]))});
    end
    s = 20'h0;
    $display("test command done");
    i_rc_model.wr(OFF_CMDSTS, 32'hc900_0140);
    pulse(20'h5a000);
    i_rc_model.rd(OFF_CMDSTS, rdv);
    chk(rdv & 32'hc900_0000, 32'hc900_0000);
    i_rc_model.wr(OFF_CMDSTS, 32'h0100_0140);
    i_rc_model.rd(OFF_CMDSTS, rdv);
    chk(rdv & 32'hc900_0000, 32'hc800_0000);
    i_rc_model.wr(OFF_CMDSTS, 32'hc800_0002);
    pulse(20'h2e007);
    i_rc_model.rd(OFF_CMDSTS, rdv);
    chk(rdv & 32'hc900_0000, 32'h0800_0000);
    $display("test flags done");
    lf = nxt(lf);
    init_ident = lf;
    pulse(20'h80000);
    i_rc_model.wr(OFF_IDENT, ~lf);
    i_rc_model.rd(OFF_IDENT, rdv);
    chk(rdv, lf);
    i_rc_model.rd(12'h008, rdv);
    chk(rdv, 32'h0);
    $display("test load done");
    wrap_up();
  end
endmodule : nt_virtual_cfg_header_bench
